// [hw/clk_sel_pkg.sv]
// Constants, types and register map of the CPU clock selector
package clk_sel_pkg;

    // Core clock and derived timing
    localparam int unsigned CLK_PERIOD_NS    = 10;
    localparam int unsigned CLK_FREQ_MHZ     = 1000 / CLK_PERIOD_NS;

    // Clock generation modes after strap decode
    typedef enum logic [1:0] {
        MODE_PLL      = 2'b00,
        MODE_DIRECT   = 2'b01,
        MODE_PRESCALE = 2'b10
    } clk_mode_t;

    // Strap codes on clock_strap_pins
    localparam logic [2:0] STRAP_X4       = 3'h7;
    localparam logic [2:0] STRAP_X3       = 3'h6;
    localparam logic [2:0] STRAP_X2       = 3'h5;
    localparam logic [2:0] STRAP_X5       = 3'h4;
    localparam logic [2:0] STRAP_DIRECT   = 3'h3;
    localparam logic [2:0] STRAP_X1_5     = 3'h2;
    localparam logic [2:0] STRAP_PRESCALE = 3'h1;
    localparam logic [2:0] STRAP_X2_5     = 3'h0;

    // CPU clock edges per input period, i.e. twice the factor F
    localparam logic [3:0] EDGES_X4       = 4'h8;
    localparam logic [3:0] EDGES_X3       = 4'h6;
    localparam logic [3:0] EDGES_X2       = 4'h4;
    localparam logic [3:0] EDGES_X5       = 4'ha;
    localparam logic [3:0] EDGES_X1_5     = 4'h3;
    localparam logic [3:0] EDGES_X2_5     = 4'h5;

    // Oscillator watchdog overflow count in loop clock cycles
    localparam int unsigned WDOG_LIMIT    = 16;
    // Core cycles per free-running loop clock cycle
    localparam int unsigned PLL_FREE_DIV  = 4;
    // Input period assumed before the first measurement
    localparam logic [15:0] PERIOD_RST    = 16'h0010;

    // Register indices on the plain register port
    localparam logic [3:0] ADDR_SYSCFG    = 4'h0;
    localparam logic [3:0] ADDR_BUSCFG    = 4'h1;
    localparam logic [3:0] ADDR_STATUS    = 4'h2;
    localparam logic [3:0] ADDR_TIMING    = 4'h3;

    // Field positions
    localparam int unsigned OWD_DIS_POS   = 4;
    localparam int unsigned MCTC_POS      = 0;
    localparam int unsigned MTTC_POS      = 5;
    localparam int unsigned ALECTL_POS    = 9;
    localparam int unsigned IRQ_POS       = 6;

    // Reset values
    localparam logic [15:0] SYSCFG_RST    = 16'h0000;
    localparam logic [15:0] BUSCFG_RST    = 16'h0000;

    // Bus timing formula constants
    localparam logic [4:0] MCTC_BASE      = 5'h0f;
    localparam logic [1:0] MTTC_BASE      = 2'h1;

    // Bus timing in half CPU clock periods
    typedef struct packed {
        logic [1:0] tri_hp;
        logic [4:0] wait_hp;
        logic [0:0] ale_hp;
    } mem_timing_t;

endpackage : clk_sel_pkg

// [hw/osc_watchdog.sv]
// Oscillator watchdog counter with sticky failure flag
`timescale 1ns/100ps
`default_nettype none
module osc_watchdog
    import clk_sel_pkg::*;
#(
    parameter int unsigned LIMIT = WDOG_LIMIT
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // Control
    input  wire logic enable,
    input  wire logic pll_tick,
    input  wire logic osc_edge,
    // Result
    output var  logic fail,
    output var  logic fail_pulse
);

    localparam int unsigned CW = $clog2(LIMIT) + 1;

    generate
        if (LIMIT < 2) begin : g_chk
            $error("osc_watchdog: LIMIT must be at least 2");
        end
    endgenerate

    logic [CW-1:0] cnt_r;
    logic          overflow;

    // Last loop cycle with no input transition in the window
    assign overflow = enable && !fail && pll_tick && !osc_edge &&
                      (cnt_r == CW'(LIMIT - 1));                         // [R9]

    // Input transitions clear the count; failure holds until reset
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_r      <= '0;
            fail       <= 1'b0;
            fail_pulse <= 1'b0;
        end else begin
            fail_pulse <= overflow;
            if (overflow) begin
                fail <= 1'b1;                                            // [R10]
            end
            if (!enable || osc_edge) begin
                cnt_r <= '0;                                             // [R8]
            end else if (pll_tick && !fail) begin
                cnt_r <= cnt_r + CW'(1);                                 // [R8]
            end
        end
    end

endmodule : osc_watchdog
`default_nettype wire

// [hw/cpu_clock_select.sv]
// CPU clock source selector with oscillator watchdog and bus timing variables
//
// Contract
// R1: Clock generation mode is chosen from three strap pins held during reset.
// R2: PLL modes multiply input frequency by 4, 3, 2, 5, 1.5 or 2.5.
// R3: Strap 001 divides the input by two; each half period is one input period.
// R4: Strap 011 turns the loop off and passes the input through directly; the loop stays on, free-running, while the watchdog is enabled.
// R5: Other codes enable the loop and resync CPU clock to input transitions.
// R6: Watchdog acts only in direct and prescaler modes, enabled after each reset.
// R7: Writing one to configuration bit 4 disables watchdog and switches loop off.
// R8: Enabled watchdog: loop free-runs, counts; each input transition clears count.
// R9: Sixteen loop cycles without transition: switch to loop clock, raise request.
// R10: After a failure switch the CPU stays on the loop clock until reset.
// R11: Watchdog disabled: CPU clock from the input, loop powered down.
// R12: Both CPU clock edges start operations; one half period is the time unit.
// R13: ALE extension, waitstate and tristate times derive from bus config fields.
// R14: Strap code latched at reset release and held until the next reset.
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/100ps
`default_nettype none
module cpu_clock_select
    import clk_sel_pkg::*;
#(
    parameter int unsigned FREE_DIV = PLL_FREE_DIV,
    parameter int unsigned WD_LIMIT = WDOG_LIMIT
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // Straps and oscillator input
    input  wire logic [2:0]  clock_strap_pins,
    input  wire logic        osc_input_pin,
    // Register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output var  logic [15:0] reg_rdata,
    // Clock outputs to core and bus controller
    output var  logic        cpu_clk,
    output var  logic        cpu_edge,
    output var  logic        pll_enable,
    output var  logic        osc_fail_irq,
    output var  mem_timing_t mem_timing
);

    generate
        if (FREE_DIV < 2) begin : g_chk_div
            $error("cpu_clock_select: FREE_DIV must be at least 2");
        end
        if (WD_LIMIT < 2) begin : g_chk_wd
            $error("cpu_clock_select: WD_LIMIT must be at least 2");
        end
    endgenerate

    localparam int unsigned DW = $clog2(FREE_DIV);

    // Strap and mode state
    logic        strap_taken_r;
    logic [2:0]  strap_r;
    clk_mode_t   mode_r;
    clk_mode_t   mode_nxt;
    logic [3:0]  edges_r;
    logic [3:0]  edges_nxt;

    // Input edge detection and period measurement
    logic        osc_prev_r;
    logic        osc_rise;
    logic        osc_toggle;
    logic [15:0] per_cnt_r;
    logic [15:0] period_r;

    // Synthesised loop clock
    logic [19:0] acc_r;
    logic [19:0] acc_sum;
    logic        acc_wrap;
    logic        synth_edge;

    // Free-running loop clock
    logic [DW-1:0] div_r;
    logic          pll_tick;

    // Registers and watchdog
    logic [15:0] syscfg_r;
    logic [15:0] buscfg_r;
    logic        irq_r;
    logic        owd_dis;
    logic        owd_active;
    logic        wd_fail;
    logic        wd_fail_pulse;
    logic        edge_sel;
    logic        pll_on;
    mem_timing_t timing_nxt;

    // Strap decode to mode and edges per input period
    always_comb begin
        mode_nxt  = MODE_PLL;                                            // [R5]
        edges_nxt = EDGES_X4;
        unique case (clock_strap_pins)
            STRAP_X4:       edges_nxt = EDGES_X4;                        // [R2]
            STRAP_X3:       edges_nxt = EDGES_X3;                        // [R2]
            STRAP_X2:       edges_nxt = EDGES_X2;                        // [R2]
            STRAP_X5:       edges_nxt = EDGES_X5;                        // [R2]
            STRAP_X1_5:     edges_nxt = EDGES_X1_5;                      // [R2]
            STRAP_X2_5:     edges_nxt = EDGES_X2_5;                      // [R2]
            STRAP_DIRECT:   mode_nxt  = MODE_DIRECT;                     // [R4]
            STRAP_PRESCALE: mode_nxt  = MODE_PRESCALE;                   // [R3]
        endcase
    end

    // Straps caught on the first edge after release, then frozen
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            strap_taken_r <= 1'b0;
            strap_r       <= STRAP_X4;
            mode_r        <= MODE_PLL;
            edges_r       <= EDGES_X4;
        end else if (!strap_taken_r) begin
            strap_taken_r <= 1'b1;                                       // [R14]
            strap_r       <= clock_strap_pins;                           // [R1]
            mode_r        <= mode_nxt;                                   // [R1]
            edges_r       <= edges_nxt;
        end
    end

    // Input transitions; masked until the straps are latched and the history holds a real sample
    assign osc_rise   = strap_taken_r && osc_input_pin && !osc_prev_r;
    assign osc_toggle = strap_taken_r && (osc_input_pin ^ osc_prev_r);

    // Input period in core cycles, saturating on a stopped input
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            osc_prev_r <= 1'b0;
            per_cnt_r  <= 16'h0000;
            period_r   <= PERIOD_RST;
        end else begin
            osc_prev_r <= osc_input_pin;
            if (osc_rise) begin
                per_cnt_r <= 16'h0001;
                period_r  <= per_cnt_r;
            end else if (per_cnt_r != 16'hffff) begin
                per_cnt_r <= per_cnt_r + 16'h0001;
            end
        end
    end

    // Phase accumulator spreads edges_r edges over one input period
    assign acc_sum    = acc_r + {16'h0000, edges_r};
    assign acc_wrap   = (acc_sum >= {4'h0, period_r}) && (period_r != 16'h0000);
    assign synth_edge = osc_rise || acc_wrap;                            // [R2]

    // Every input rise realigns the phase so drift never builds up
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            acc_r <= 20'h00000;
        end else if (osc_rise) begin
            acc_r <= 20'h00000;                                          // [R5]
        end else if (acc_wrap) begin
            acc_r <= acc_sum - {4'h0, period_r};
        end else begin
            acc_r <= acc_sum;
        end
    end

    // Free-running loop clock as one-cycle enable, idle while powered down
    assign pll_tick = pll_on && (div_r == DW'(FREE_DIV - 1));

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            div_r <= '0;
        end else if (!pll_on || pll_tick) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + DW'(1);
        end
    end

    // Watchdog only in direct and prescaler modes, unless disabled
    assign owd_dis    = syscfg_r[OWD_DIS_POS];                           // [R7]
    assign owd_active = strap_taken_r && (mode_r != MODE_PLL) && !owd_dis; // [R6]

    // Loop on for multiplier modes, or free-running for the watchdog
    assign pll_on = strap_taken_r &&
                    ((mode_r == MODE_PLL) || owd_active || wd_fail);     // [R8] [R11]

    osc_watchdog #(
        .LIMIT      (WD_LIMIT)
    ) u_osc_watchdog (
        .clk        (clk),
        .reset      (reset),
        .enable     (owd_active),
        .pll_tick   (pll_tick),
        .osc_edge   (osc_toggle),
        .fail       (wd_fail),
        .fail_pulse (wd_fail_pulse)
    );

    // Clock edge source per mode; a failure overrides until reset
    always_comb begin
        edge_sel = 1'b0;
        if (wd_fail) begin
            edge_sel = pll_tick;                                         // [R9] [R10]
        end else begin
            unique case (mode_r)
                MODE_PLL:      edge_sel = synth_edge;                    // [R5]
                MODE_DIRECT:   edge_sel = osc_toggle;                    // [R4] [R11]
                MODE_PRESCALE: edge_sel = osc_rise;                      // [R3]
                default:       edge_sel = 1'b0;
            endcase
        end
    end

    // CPU clock and edge strobe; each strobe opens one half period
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cpu_clk    <= 1'b0;
            cpu_edge   <= 1'b0;
            pll_enable <= 1'b0;
        end else begin
            cpu_edge   <= strap_taken_r && edge_sel;                     // [R12]
            pll_enable <= pll_on;                                        // [R7]
            if (strap_taken_r && edge_sel) begin
                cpu_clk <= !cpu_clk;                                     // [R12]
            end
        end
    end

    // Failure request: set wins over a write-one clear in the same cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_r <= 1'b0;
        end else if (wd_fail_pulse) begin
            irq_r <= 1'b1;                                               // [R9]
        end else if (reg_wr && (reg_addr == ADDR_STATUS) && reg_wdata[IRQ_POS]) begin
            irq_r <= 1'b0;
        end
    end

    assign osc_fail_irq = irq_r;

    // Configuration registers; disable bit clears on every reset
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            syscfg_r <= SYSCFG_RST;                                      // [R6]
            buscfg_r <= BUSCFG_RST;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_SYSCFG) begin
                syscfg_r <= reg_wdata;                                   // [R7]
            end
            if (reg_addr == ADDR_BUSCFG) begin
                buscfg_r <= reg_wdata;
            end
        end
    end

    // Bus timing variables in half periods
    assign timing_nxt.ale_hp  = buscfg_r[ALECTL_POS];                    // [R13]
    assign timing_nxt.wait_hp = 5'((MCTC_BASE - {1'b0, buscfg_r[MCTC_POS +: 4]}) << 1); // [R13]
    assign timing_nxt.tri_hp  = 2'((MTTC_BASE - {1'b0, buscfg_r[MTTC_POS]}) << 1);      // [R13]

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mem_timing <= '0;
        end else begin
            mem_timing <= timing_nxt;
        end
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                ADDR_SYSCFG: reg_rdata <= syscfg_r;
                ADDR_BUSCFG: reg_rdata <= buscfg_r;
                ADDR_STATUS: reg_rdata <= {8'h00, pll_on, irq_r, wd_fail, mode_r, strap_r};
                ADDR_TIMING: reg_rdata <= {8'h00, mem_timing};
                default:     reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

endmodule : cpu_clock_select
`default_nettype wire

// [tb/osc_source.sv]
// Behavioural oscillator driving the clock input pin
`timescale 1ns/100ps
`default_nettype none
module osc_source #(
    parameter int HALF = 12
) (
    // Clock
    input  wire logic clk,
    // Control
    input  wire logic run,
    // Oscillator pin
    output var  logic osc_input_pin
);
    int   cnt   = 0;
    logic lvl_r = 1'b0;

    // A stopped source freezes at its level, as a dead crystal would
    assign osc_input_pin = lvl_r;
    always @(posedge clk) begin
        if (run) begin
            cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
            if (cnt == HALF - 1) lvl_r <= !lvl_r;
        end
    end
endmodule : osc_source
`default_nettype wire

// [tb/clk_sel_properties.sv]
// Port-level checker of the CPU clock selector
`timescale 1ns/100ps
`default_nettype none
module clk_sel_properties
    import clk_sel_pkg::*;
#(
    parameter int unsigned FREE_DIV = PLL_FREE_DIV,
    parameter int unsigned WD_LIMIT = WDOG_LIMIT
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // Inputs
    input  wire logic [2:0]  clock_strap_pins,
    input  wire logic        osc_input_pin,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    // Outputs
    input  wire logic [15:0] reg_rdata,
    input  wire logic        cpu_clk,
    input  wire logic        cpu_edge,
    input  wire logic        pll_enable,
    input  wire logic        osc_fail_irq,
    input  wire mem_timing_t mem_timing
);
    // Margins absorb tick phase and output registers
    localparam int LO = FREE_DIV * (WD_LIMIT - 1) - 4;
    localparam int HI = FREE_DIV * (WD_LIMIT + 2) + 4;
    logic [2:0] strap_r;
    logic [1:0] up_r;
    logic       dis_r;
    logic       failed_r;
    logic [7:0] quiet_r;
    wire        wd_mode = (strap_r == STRAP_DIRECT) || (strap_r == STRAP_PRESCALE);
    wire        live = (up_r == 2'h3);

    // Shadow of strap, disable bit, failure and input silence
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            strap_r  <= 3'h0;
            up_r     <= 2'h0;
            dis_r    <= 1'b0;
            failed_r <= 1'b0;
            quiet_r  <= 8'h00;
        end else begin
            if (up_r == 2'h0) strap_r <= clock_strap_pins;
            if (!live) up_r <= up_r + 2'h1;
            if (reg_wr && reg_addr == ADDR_SYSCFG) dis_r <= reg_wdata[OWD_DIS_POS];
            if (osc_fail_irq) failed_r <= 1'b1;
            quiet_r <= $changed(osc_input_pin) ? 8'h00 : quiet_r + {7'h0, quiet_r != 8'hff};
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    AST_EDGE_TOGGLE: assert property (cpu_edge == $changed(cpu_clk))
        else $error("cpu edge pulse and clock change disagree");
    AST_LOOP_ON: assert property (live && (!wd_mode || !dis_r) |-> pll_enable)
        else $error("loop off while required");
    AST_LOOP_OFF: assert property (wd_mode && dis_r && $past(dis_r, 2) && !failed_r && !osc_fail_irq
        |-> !pll_enable)
        else $error("loop still on with watchdog disabled");
    AST_DIRECT_FOLLOW: assert property (strap_r == STRAP_DIRECT && live && !failed_r
        && $changed(osc_input_pin) |-> ##[1:3] cpu_edge)
        else $error("direct mode missed an input transition");
    AST_PRESCALE_RISE: assert property (strap_r == STRAP_PRESCALE && live && !failed_r
        && $rose(osc_input_pin) |-> ##[1:3] cpu_edge)
        else $error("prescaler missed an input rise");
    AST_WD_FIRES: assert property (quiet_r == HI[7:0] && wd_mode && !dis_r && live |-> osc_fail_irq)
        else $error("watchdog did not fire on silent input");
    AST_WD_QUIET: assert property (quiet_r < LO[7:0] |-> !$rose(osc_fail_irq))
        else $error("watchdog fired before overflow");
    AST_WD_MODE_ONLY: assert property ($rose(osc_fail_irq) |-> wd_mode && !dis_r)
        else $error("watchdog fired outside its modes");
    AST_IRQ_STICKY: assert property (osc_fail_irq && !(reg_wr && reg_addr == ADDR_STATUS
        && reg_wdata[IRQ_POS]) |=> osc_fail_irq)
        else $error("fail request dropped without clear");
    AST_FREE_RUN: assert property (failed_r && cpu_edge |=> (!cpu_edge)[*3] ##1 cpu_edge)
        else $error("cpu edges left the free-running loop");
endmodule : clk_sel_properties

bind cpu_clock_select clk_sel_properties #(.FREE_DIV(FREE_DIV), .WD_LIMIT(WD_LIMIT)) clk_sel_properties_inst (
    .clk, .reset, .clock_strap_pins, .osc_input_pin, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .cpu_clk, .cpu_edge, .pll_enable, .osc_fail_irq, .mem_timing);
`default_nettype wire

// [tb/testbench.sv]
// Self-checking testbench of the CPU clock selector
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import clk_sel_pkg::*;
    localparam int FDIV = 4;
    logic        clk;
    logic        reset;
    logic        reg_wr;
    logic        reg_rd;
    logic        osc_run;
    logic        osc_pin;
    logic        cpu_clk;
    logic        cpu_edge;
    logic        pll_enable;
    logic        osc_fail_irq;
    logic [2:0]  straps;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic [15:0] rd_data;
    mem_timing_t mem_timing;
    int          miscompares = 0;
    int          compares = 0;
    int          cycles = 0;
    // CPU edges per input period, by strap code
    int          exp_edges [8] = '{5, 1, 3, 2, 10, 4, 6, 8};

    osc_source #(.HALF(12)) osc_source_inst (.clk(clk), .run(osc_run), .osc_input_pin(osc_pin));
    cpu_clock_select #(.FREE_DIV(FDIV)) cpu_clock_select_inst (
        .clk(clk), .reset(reset), .clock_strap_pins(straps), .osc_input_pin(osc_pin),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .cpu_clk(cpu_clk), .cpu_edge(cpu_edge), .pll_enable(pll_enable),
        .osc_fail_irq(osc_fail_irq), .mem_timing(mem_timing));

    task automatic give_verdict();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    // Counts edges over ten input periods; window alignment allows two either way
    task automatic chk_edges(input int exp);
        int n;
        n = 0;
        repeat (240) begin
            @(posedge clk);
            #1 if (cpu_edge === 1'b1) n++;
        end
        compares++;
        if (n > exp + 2 || n + 2 < exp) begin
            miscompares++;
            $display("wrong value edge count: expected %0d, seen %0d", exp, n);
        end
    endtask : chk_edges

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 rd_data = reg_rdata;
    endtask : rd

    // Straps move after latching so that holding them is exercised
    task automatic do_reset(input logic [2:0] s);
        @(posedge clk);
        reset   <= 1'b1;
        straps  <= s;
        osc_run <= 1'b1;
        repeat (5) @(posedge clk);
        reset   <= 1'b0;
        repeat (3) @(posedge clk);
        straps  <= ~s;
    endtask : do_reset

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            give_verdict();
        end
    end

    initial begin
        reset = 1'b1;
        straps = 3'h7;
        reg_addr = 4'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        osc_run = 1'b1;
        for (int s = 0; s < 8; s++) begin
            do_reset(3'(s));
            rd(ADDR_STATUS);
            chk("strap", 16'(s), {13'h0, rd_data[2:0]});
            chk("mode", (s == 3) ? 16'h1 : (s == 1) ? 16'h2 : 16'h0, {14'h0, rd_data[4:3]});
            repeat (96) @(posedge clk);
            chk_edges(exp_edges[s] * 10);
            chk("pll_enable", 16'h1, {15'h0, pll_enable});
        end
        chk("timing port", 16'({2'h2, 5'h1e, 1'b0}), {8'h0, mem_timing});
        wr(ADDR_BUSCFG, 16'h0223);
        rd(ADDR_TIMING);
        chk("timing", 16'({2'h0, 5'h18, 1'b1}), rd_data);
        wr(ADDR_BUSCFG, 16'h000f);
        rd(4'hf);
        chk("unmapped", 16'h0000, rd_data);
        chk("timing port", 16'({2'h2, 5'h00, 1'b0}), {8'h0, mem_timing});
        do_reset(STRAP_DIRECT);
        osc_run <= 1'b0;
        repeat (100) @(posedge clk);
        #1 chk("fail irq", 16'h1, {15'h0, osc_fail_irq});
        // Loop on, request, failure, direct mode, strap 011
        rd(ADDR_STATUS);
        chk("fail status", 16'h00eb, rd_data);
        osc_run <= 1'b1;
        chk_edges(240 / FDIV);
        wr(ADDR_STATUS, 16'h0040);
        repeat (2) @(posedge clk);
        #1 chk("irq clear", 16'h0, {15'h0, osc_fail_irq});
        do_reset(STRAP_PRESCALE);
        wr(ADDR_SYSCFG, 16'h0010);
        repeat (2) @(posedge clk);
        #1 chk("loop off", 16'h0, {15'h0, pll_enable});
        osc_run <= 1'b0;
        repeat (100) @(posedge clk);
        #1 chk("no irq", 16'h0, {15'h0, osc_fail_irq});
        osc_run <= 1'b1;
        repeat (48) @(posedge clk);
        chk_edges(10);
        do_reset(STRAP_X4);
        osc_run <= 1'b0;
        repeat (100) @(posedge clk);
        #1 chk("pll no irq", 16'h0, {15'h0, osc_fail_irq});
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
